// ===== hdl/lmk_pkg.sv
// constants shared by the led matrix serial command and key scan block
package lmk_pkg;
    localparam int MEM_BYTES = 14;
    localparam logic [3:0] ADDR_INIT = 4'h0;
    localparam logic [3:0] ADDR_LAST = 4'hD;
    localparam logic [3:0] ADDR_TOP = 4'hF;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam logic [1:0] CMD_MODE = 2'h0;
    localparam logic [1:0] CMD_DATA = 2'h1;
    localparam logic [1:0] CMD_CTRL = 2'h2;
    localparam logic [1:0] CMD_ADDR = 2'h3;
    localparam logic [1:0] MODE_7G_11S = 2'h3;
    localparam logic [3:0] DATA_INIT = 4'h0;
    localparam logic [1:0] DATA_READ_KEYS = 2'h2;
    localparam logic [2:0] PW_INIT = 3'h0;
    localparam logic [2:0] GRIDS_SEVEN = 3'h7;
    localparam logic [2:0] GRIDS_SIX = 3'h6;
    localparam logic [2:0] GRID_SEVENTH = 3'h6;
    localparam logic [3:0] SUBTICK_LAST = 4'hF;
    localparam logic [3:0] KEY_SUBTICKS = 4'hA;
    localparam logic [3:0] KEY_HALF = 4'h5;
    localparam logic [5:0] KEY_BIT_LAST = 6'h27;
    localparam logic [15:0] SUB_LEN_INIT = 16'h0100;
    localparam logic [11:0] REG_TIMING = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_KEYS_LO = 12'h008;
    localparam logic [11:0] REG_KEYS_HI = 12'h00C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/lmk_top.sv
// led matrix serial command interpreter with display scan and key scan
// Operation
// - first byte after strobe falls is a command byte
// - strobe rising mid-byte resets receiver and discards the partial byte
// - sample data on clock rise, drive on fall, ignore clock if strobe high
// - display mode command has top bits zero; bits b2 to b5 ignored
// - mode picks eleven segments seven grids or twelve segments six grids
// - a mode change blanks display until display control switches it on
// - mode command repeating the current mode does nothing
// - power-up mode is seven grids eleven segments
// - data setting command chooses display write or key read
// - power-up clears low four bits of data setting
// - ten by three key matrix stored in readable key memory
// - key bits shift out byte after byte, b0 first, without a gap
// - top two bits of each key byte carry no key information
// - key returns latched into key storage at end of each display cycle
// - address command loads pointer; 00H to 0DH valid
// - pointer at 0EH or above discards display data
// - power-up pointer is zero
// - two bytes per grid row, seven rows, full low byte and low nibble of high byte
// - display control sets on or off and one of eight widths
// - power-up width one sixteenth, display off, key scan running
// - one key scan spans two display frames
// - first ten segment outputs drive the key matrix sources
// - successive data bytes go to incrementing addresses
module lmk_top (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic strobe_line_i,
    input wire logic shift_clk_i,
    input wire logic serial_bidir_pin_i,
    output logic serial_bidir_pin_o,
    output logic serial_bidir_pin_oe_o,
    input wire logic [2:0] key_return_inputs_i,
    output logic [9:0] segment_key_source_o,
    output logic segment_eleven_o,
    output logic segment_or_grid_output_o,
    output logic [5:0] grid_output_o,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] k1;
        logic [2:0] k2;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic first;
        logic reading;
        logic [5:0] rd_idx;
        logic [1:0] mode;
        logic [3:0] data_cfg;
        logic on;
        logic [2:0] pw;
        logic [3:0] ptr;
        logic [13:0][7:0] mem;
        logic [39:0] keys;
        logic [39:0] shadow;
        logic [15:0] sub_len;
        logic [15:0] sub_cnt;
        logic [3:0] subtick;
        logic [2:0] slot;
        logic frame_odd;
        logic dio;
        logic dio_oe;
        logic [11:0] seg;
        logic [5:0] grid;
        logic seg_or_grid;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [11:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lmk_state_t;

    lmk_state_t q;
    lmk_state_t n;

    // helper flags, also watched by the assertions
    logic cmd_done;
    logic [7:0] cmd_byte;
    logic frame_end;
    logic clk_fall;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] key_bit_index(input logic [3:0] src,
                                                 input logic [1:0] ret);
        return {src[3:1], 3'h0}
               + (src[0] ? 6'h03 : 6'h00) + {4'h0, ret};
    endfunction

    function automatic logic [3:0] ptr_step(input logic [3:0] p);
        return (p == lmk_pkg::ADDR_TOP) ? p : p + 4'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic strobe_hi;
        logic clk_rise;
        logic din;
        logic [7:0] rx;
        logic [2:0] ngrids;
        logic tick_end;
        logic slot_end;
        logic [3:0] src;
        logic [3:0] wgrid;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [31:0] wval;
        strobe_hi = 1'b0;
        clk_rise = 1'b0;
        din = 1'b0;
        rx = 8'h00;
        ngrids = lmk_pkg::GRIDS_SIX;
        tick_end = 1'b0;
        slot_end = 1'b0;
        src = 4'h0;
        wgrid = 4'h0;
        lo = 8'h00;
        hi = 8'h00;
        wval = 32'h0000_0000;
        n = q;
        cmd_done = 1'b0;
        cmd_byte = 8'h00;
        frame_end = 1'b0;

        // two flops per pin before any logic looks at it
        n.s1 = {strobe_line_i, shift_clk_i, serial_bidir_pin_i};
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.k1 = key_return_inputs_i;
        n.k2 = q.k1;
        strobe_hi = q.s2[2];
        clk_rise = q.s2[1] & ~q.s3[1];
        clk_fall = ~q.s2[1] & q.s3[1];
        din = q.s2[0];
        rx = {din, q.shift[7:1]};

        ////////////////////////////////////////////////////////////////////
        // serial receiver and command decode
        if (strobe_hi)
        begin
            // clock ignored; any partial byte is dropped here
            n.bit_cnt = 4'h0;
            n.first = 1'b1;
            n.reading = 1'b0;
            n.dio_oe = 1'b0;
        end
        else if (clk_rise && !q.reading)
        begin
            n.shift = rx;
            if (q.bit_cnt == lmk_pkg::BYTE_LAST_BIT)
            begin
                n.bit_cnt = 4'h0;
                if (q.first)
                begin
                    n.first = 1'b0;
                    cmd_done = 1'b1;
                    cmd_byte = rx;
                    case (rx[7:6])
                        lmk_pkg::CMD_MODE:
                        begin
                            // b2..b5 unused; same mode leaves all alone
                            if (rx[1:0] != q.mode)
                            begin
                                n.mode = rx[1:0];
                                n.on = 1'b0;
                            end
                        end
                        lmk_pkg::CMD_DATA:
                        begin
                            n.data_cfg = rx[3:0];
                            n.reading = (rx[1:0] ==
                                         lmk_pkg::DATA_READ_KEYS);
                            n.rd_idx = 6'h00;
                        end
                        lmk_pkg::CMD_CTRL:
                        begin
                            n.on = rx[3];
                            n.pw = rx[2:0];
                        end
                        lmk_pkg::CMD_ADDR:
                        begin
                            n.ptr = rx[3:0];
                        end
                        default:
                        begin
                            n.first = 1'b0;
                        end
                    endcase
                end
                else if (q.ptr <= lmk_pkg::ADDR_LAST)
                begin
                    n.mem[q.ptr] = rx;
                    n.ptr = ptr_step(q.ptr);
                end
            end
            else
            begin
                n.bit_cnt = q.bit_cnt + 4'h1;
            end
        end
        else if (clk_fall && q.reading)
        begin
            // open drain: pull low for a zero, release for a one
            n.dio_oe = ~q.keys[q.rd_idx];
            n.rd_idx = (q.rd_idx == lmk_pkg::KEY_BIT_LAST) ? 6'h00
                       : q.rd_idx + 6'h01;
        end

        ////////////////////////////////////////////////////////////////////
        // display and key scan timing
        ngrids = (q.mode == lmk_pkg::MODE_7G_11S) ? lmk_pkg::GRIDS_SEVEN
                 : lmk_pkg::GRIDS_SIX;
        tick_end = ({1'b0, q.sub_cnt} + 17'h00001) >= {1'b0, q.sub_len};
        slot_end = tick_end && (q.subtick == lmk_pkg::SUBTICK_LAST);
        frame_end = slot_end && (q.slot >= ngrids);
        n.sub_cnt = tick_end ? 16'h0000 : q.sub_cnt + 16'h0001;
        if (tick_end)
        begin
            n.subtick = q.subtick + 4'h1;
        end
        if (slot_end)
        begin
            n.slot = frame_end ? 3'h0 : q.slot + 3'h1;
        end
        if (frame_end)
        begin
            n.frame_odd = ~q.frame_odd;
            n.keys = q.shadow;
        end
        src = (q.frame_odd ? lmk_pkg::KEY_HALF : 4'h0)
              + {1'b0, q.subtick[3:1]};
        n.seg = 12'h000;
        n.grid = 6'h00;
        n.seg_or_grid = 1'b0;
        if (q.slot >= ngrids)
        begin
            // key slot keeps running even with the display off
            if (q.subtick < lmk_pkg::KEY_SUBTICKS)
            begin
                n.seg[src] = 1'b1;
                if (tick_end && q.subtick[0])
                begin
                    for (int r = 0; r < 3; r++)
                    begin
                        n.shadow[key_bit_index(src, 2'(r))] = q.k2[r];
                    end
                end
            end
        end
        else if (q.on && ({1'b0, q.subtick} < {1'b0, q.pw, 1'b1}))
        begin
            wgrid = {1'b0, q.slot};
            lo = q.mem[{wgrid[2:0], 1'b0}];
            hi = q.mem[{wgrid[2:0], 1'b1}];
            n.seg = {hi[3:0], lo};
            if (q.slot == lmk_pkg::GRID_SEVENTH)
            begin
                n.seg_or_grid = 1'b1;
            end
            else
            begin
                n.grid[q.slot] = 1'b1;
            end
            if (ngrids == lmk_pkg::GRIDS_SIX)
            begin
                n.seg_or_grid = hi[3];
            end
        end

        ////////////////////////////////////////////////////////////////////
        // axi4-lite slave
        if (s_axi_awvalid && q.awready)
        begin
            n.aw_got = 1'b1;
            n.awready = 1'b0;
            n.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready)
        begin
            n.w_got = 1'b1;
            n.wready = 1'b0;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (q.aw_got && q.w_got && !q.bvalid)
        begin
            n.bvalid = 1'b1;
            n.bresp = lmk_pkg::RESP_SLVERR;
            if (q.waddr == lmk_pkg::REG_TIMING)
            begin
                n.bresp = lmk_pkg::RESP_OKAY;
                wval = {16'h0000, q.sub_len};
                for (int b = 0; b < 2; b++)
                begin
                    if (q.wstrb[b])
                    begin
                        wval[b*8 +: 8] = q.wdata[b*8 +: 8];
                    end
                end
                n.sub_len = wval[15:0];
            end
        end
        if (q.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end
        if (s_axi_arvalid && q.arready)
        begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = lmk_pkg::RESP_OKAY;
            case (s_axi_araddr)
                lmk_pkg::REG_TIMING: n.rdata = {16'h0000, q.sub_len};
                lmk_pkg::REG_STATUS: n.rdata = {17'h00000, q.reading,
                    q.ptr, q.data_cfg, q.mode, q.pw, q.on};
                lmk_pkg::REG_KEYS_LO: n.rdata = q.keys[31:0];
                lmk_pkg::REG_KEYS_HI: n.rdata = {24'h000000, q.keys[39:32]};
                default:
                begin
                    n.rdata = 32'h0000_0000;
                    n.rresp = lmk_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (q.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.first <= 1'b1;
            q.mode <= lmk_pkg::MODE_7G_11S;
            q.data_cfg <= lmk_pkg::DATA_INIT;
            q.pw <= lmk_pkg::PW_INIT;
            q.on <= 1'b0;
            q.ptr <= lmk_pkg::ADDR_INIT;
            q.sub_len <= lmk_pkg::SUB_LEN_INIT;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end
        else
        begin
            q <= n;
        end
    end

    assign serial_bidir_pin_o = q.dio;
    assign serial_bidir_pin_oe_o = q.dio_oe;
    assign segment_key_source_o = q.seg[9:0];
    assign segment_eleven_o = q.seg[10];
    assign segment_or_grid_output_o = q.seg_or_grid;
    assign grid_output_o = q.grid;
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    ////////////////////////////////////////////////////////////////////////
    strobe_abort_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        q.s2[2] |=> (q.bit_cnt == 4'h0) && q.first)
        else $error("strobe high did not reset the receiver");

    idle_release_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        q.s2[2] |=> !serial_bidir_pin_oe_o)
        else $error("data pin driven while strobe high");

    mode_blank_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        cmd_done && cmd_byte[7:6] == lmk_pkg::CMD_MODE
        && cmd_byte[1:0] != q.mode |=> !q.on ##1 grid_output_o == 6'h00)
        else $error("mode change did not blank the display");

    same_mode_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        cmd_done && cmd_byte[7:6] == lmk_pkg::CMD_MODE
        && cmd_byte[1:0] == q.mode |=> $stable(q.on) && $stable(q.mode))
        else $error("repeated mode command had an effect");

    addr_load_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        cmd_done && cmd_byte[7:6] == lmk_pkg::CMD_ADDR
        |=> q.ptr == $past(cmd_byte[3:0]))
        else $error("address command did not load the pointer");

    bad_addr_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        q.ptr > lmk_pkg::ADDR_LAST |=> $stable(q.mem))
        else $error("display memory written at invalid address");

    off_dark_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !q.on |=> grid_output_o == 6'h00 && !segment_eleven_o)
        else $error("outputs active while display off");

    key_latch_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !frame_end |=> $stable(q.keys))
        else $error("key storage changed outside frame end");

    key_wrap_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        q.reading && clk_fall && !q.s2[2]
        && q.rd_idx == lmk_pkg::KEY_BIT_LAST |=> q.rd_idx == 6'h00)
        else $error("key read did not wrap after the last bit");

    write_resp_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        s_axi_bvalid |=> ($past(s_axi_bready) ? !s_axi_bvalid
        : s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write response dropped before ready");
endmodule

// ===== dv/lmk_host.sv
// host side model driving the three-wire display link
module lmk_host (
    input wire logic clk_i,
    input wire logic line_i,
    output logic strobe_o,
    output logic sclk_o,
    output logic pull_low_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // clock stands high between frames
    initial
    begin
        strobe_o = 1'b1;
        sclk_o = 1'b1;
        pull_low_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic open_frame();
        @(posedge clk_i);
        strobe_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic close_frame();
        @(posedge clk_i);
        strobe_o <= 1'b1;
        pull_low_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask

    // lsb first; data moves only while the clock is low
    task automatic put_bits(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            sclk_o <= 1'b0;
            pull_low_o <= ~b[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
    endtask

    // sampled late in the high phase: device answers clocks after the fall
    task automatic get_byte(output logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_i);
            sclk_o <= 1'b0;
            pull_low_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            b[i] = line_i;
        end
    endtask
endmodule

// ===== dv/testbench.sv
// self-checking bench: register access, link commands and key reads
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strobe, sclk, host_low, dev_low, dev_bit, dio, seg11, seg_grid;
    logic [2:0] keys;
    logic [9:0] seg;
    logic [5:0] grid;
    logic [11:0] awaddr = 12'h0;
    logic [11:0] araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int n_fail = 0;
    int tests_run = 0;

    always #10 clk = ~clk;
    // open drain with pull-up
    assign dio = ~(dev_low | host_low);
    // key matrix: return 0 on every source, return 2 on odd sources only
    assign keys = {|(seg & 10'h2AA), 1'b0, |seg};

    lmk_top lmk_top_inst (
        .sys_clk_i(clk), .rst_i(rst), .strobe_line_i(strobe),
        .shift_clk_i(sclk), .serial_bidir_pin_i(dio),
        .serial_bidir_pin_o(dev_bit), .serial_bidir_pin_oe_o(dev_low),
        .key_return_inputs_i(keys), .segment_key_source_o(seg),
        .segment_eleven_o(seg11), .segment_or_grid_output_o(seg_grid),
        .grid_output_o(grid), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1)
    );

    lmk_host lmk_host_inst (
        .clk_i(clk), .line_i(dio), .strobe_o(strobe), .sclk_o(sclk),
        .pull_low_o(host_low)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic timeout();
        n_fail++;
        $display("wait limit reached");
        report_and_stop();
    endtask

    // ready and response ride high; bready and rready tied high
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        int k;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        r = bresp;
        if (k == 50) timeout();
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int k;
        araddr <= a;
        arvalid <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        r = rresp;
        if (k == 50) timeout();
    endtask

    task automatic status(input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(lmk_pkg::REG_STATUS, d, r);
        check("status", d, exp);
    endtask

    task automatic cmd(input logic [7:0] c);
        lmk_host_inst.open_frame();
        lmk_host_inst.put_bits(c, 8);
        lmk_host_inst.close_frame();
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] b;
        logic [7:0] acc;
        int k;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        status(32'h30);
        check("dio out", 32'(dev_bit), 32'h0);
        axi_wr(lmk_pkg::REG_TIMING, 32'h2, r);
        check("timing resp", 32'(r), 32'(lmk_pkg::RESP_OKAY));
        axi_rd(lmk_pkg::REG_TIMING, d, r);
        check("timing", d, 32'h2);
        axi_rd(12'h010, d, r);
        check("unmapped", 32'(r), 32'(lmk_pkg::RESP_SLVERR));
        axi_wr(lmk_pkg::REG_STATUS, 32'hFF, r);
        check("ro write", 32'(r), 32'(lmk_pkg::RESP_SLVERR));
        // reset already zeroes the memory; clear it over the link first anyway
        cmd(8'h40);
        lmk_host_inst.open_frame();
        lmk_host_inst.put_bits(8'hC0, 8);
        for (k = 0; k < 14; k++)
            lmk_host_inst.put_bits(8'h00, 8);
        lmk_host_inst.close_frame();
        status(32'h3830);
        cmd(8'hCD);
        status(32'h3430);
        lmk_host_inst.open_frame();
        lmk_host_inst.put_bits(8'hCD, 8);
        lmk_host_inst.put_bits(8'h00, 8);
        lmk_host_inst.put_bits(8'h00, 8);
        lmk_host_inst.close_frame();
        status(32'h3830);
        repeat (1000) @(posedge clk);
        axi_rd(lmk_pkg::REG_KEYS_LO, d, r);
        check("keys lo", d, 32'h29292929);
        axi_rd(lmk_pkg::REG_KEYS_HI, d, r);
        check("keys hi", d, 32'h29);
        lmk_host_inst.open_frame();
        lmk_host_inst.put_bits(8'h42, 8);
        repeat (50) @(posedge clk);
        for (k = 0; k < 5; k++)
        begin
            lmk_host_inst.get_byte(b);
            check("key byte", 32'(b & 8'h3F), 32'h29);
        end
        lmk_host_inst.close_frame();
        cmd(8'h8F);
        cmd(8'h70);
        lmk_host_inst.open_frame();
        lmk_host_inst.put_bits(8'hC0, 8);
        lmk_host_inst.put_bits(8'h01, 8);
        lmk_host_inst.close_frame();
        status(32'h043F);
        for (k = 0; k < 3000 && grid[0] !== 1'b1; k++) @(posedge clk);
        if (k == 3000) timeout();
        check("row0 segs", 32'({seg11, seg}), 32'h1);
        for (k = 0; k < 3000 && seg_grid !== 1'b1; k++) @(posedge clk);
        if (k == 3000) timeout();
        check("grid7", 32'({seg_grid, grid}), 32'h40);
        cmd(8'h03);
        status(32'h043F);
        cmd(8'h3C);
        status(32'h040E);
        acc = 8'h00;
        repeat (600)
        begin
            @(posedge clk);
            acc = acc | {seg_grid, seg11, grid};
        end
        check("grid off", 32'(acc), 32'h0);
        lmk_host_inst.open_frame();
        lmk_host_inst.put_bits(8'h8F, 5);
        lmk_host_inst.close_frame();
        status(32'h040E);
        cmd(8'h03);
        status(32'h043E);
        report_and_stop();
    end
endmodule
